// ==== hw/mopwm_pkg.sv ====
package mopwm_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          CNT_W      = 16;
    localparam int          DIV_W      = 5;
    localparam int          NPWM       = 3;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] REG_RST    = 16'hFFFF;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;

    // ------------------------------------------------------------
    // Mode control write data field positions
    // ------------------------------------------------------------
    localparam int          MODE_RUN   = 0;
    localparam int          MODE_BFC   = 1;
    localparam int          MODE_BFD   = 2;

    // ------------------------------------------------------------
    // Synchroniser lanes
    // ------------------------------------------------------------
    localparam int          SY_EXT     = 0;
    localparam int          SY_OSC     = 1;
    localparam int          SY_IRQ0    = 2;

    // ------------------------------------------------------------
    // Count source codes and divider masks
    // ------------------------------------------------------------
    localparam logic [2:0]  SRC_F1     = 3'h0;
    localparam logic [2:0]  SRC_F2     = 3'h1;
    localparam logic [2:0]  SRC_F4     = 3'h2;
    localparam logic [2:0]  SRC_F8     = 3'h3;
    localparam logic [2:0]  SRC_F32    = 3'h4;
    localparam logic [2:0]  SRC_OSC    = 3'h5;
    localparam logic [2:0]  SRC_EXT    = 3'h6;
    localparam logic [4:0]  DIV2_MASK  = 5'h01;
    localparam logic [4:0]  DIV4_MASK  = 5'h03;
    localparam logic [4:0]  DIV8_MASK  = 5'h07;
    localparam logic [4:0]  DIV32_MASK = 5'h1F;

    // ------------------------------------------------------------
    // Interrupt-0 pin function codes
    // ------------------------------------------------------------
    localparam logic [1:0]  IRQ0_GPIO  = 2'h0;
    localparam logic [1:0]  IRQ0_CUT   = 2'h1;
    localparam logic [1:0]  IRQ0_INT   = 2'h2;

endpackage : mopwm_pkg

// ==== hw/mopwm_prescale.sv ====
`timescale 1ns/1ps
module mopwm_prescale
    import mopwm_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    mopwm_src_if.div    src
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic             tick;
    } mopwm_pre_t;

    mopwm_pre_t q;
    mopwm_pre_t next_q;

    // ------------------------------------------------------------
    // Count source selection
    // ------------------------------------------------------------

    // Divider runs free so a source change needs no restart
    always_comb
    begin
        next_q     = q;
        next_q.div = q.div + 5'h01;
        unique case (src.src_sel)
            SRC_F1:  next_q.tick = 1'b1;
            SRC_F2:  next_q.tick = (q.div & DIV2_MASK) == DIV2_MASK;
            SRC_F4:  next_q.tick = (q.div & DIV4_MASK) == DIV4_MASK;
            SRC_F8:  next_q.tick = (q.div & DIV8_MASK) == DIV8_MASK;
            SRC_F32: next_q.tick = (q.div & DIV32_MASK) == DIV32_MASK;
            SRC_OSC: next_q.tick = src.osc_rise;
            SRC_EXT: next_q.tick = src.ext_rise;
            default: next_q.tick = 1'b0; // Code 7 is illegal, no count
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= next_q;
    end

    assign src.tick = q.tick;

endmodule : mopwm_prescale

// ==== hw/mopwm_src_if.sv ====
`timescale 1ns/1ps
// Count source selection between the core and the divider
interface mopwm_src_if;
    logic [2:0] src_sel;
    logic       ext_rise;
    logic       osc_rise;
    logic       tick;

    modport core (output src_sel, output ext_rise, output osc_rise, input tick);
    modport div  (input src_sel, input ext_rise, input osc_rise, output tick);
endinterface : mopwm_src_if

// ==== hw/mopwm_top.sv ====
`timescale 1ns/1ps
module mopwm_top
    import mopwm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    // Software side
    input  wire logic              mode_ctrl_wr,
    input  wire logic [2:0]        mode_ctrl_data,
    input  wire logic [2:0]        count_src_sel,
    input  wire logic [NPWM-1:0]   pwm_enable,
    input  wire logic [NPWM-1:0]   active_high,
    input  wire logic              output_ctrl_wr,
    input  wire logic [NPWM-1:0]   init_level,
    input  wire logic [1:0]        irq0_func,
    input  wire logic              wr_counter,
    input  wire logic              wr_period,
    input  wire logic              wr_general_b,
    input  wire logic              wr_general_c,
    input  wire logic              wr_general_d,
    input  wire logic [CNT_W-1:0]  wr_data,
    input  wire logic [3:0]        gpio_out,
    input  wire logic [3:0]        gpio_oe,
    output logic [CNT_W-1:0]       pwm_counter,
    output logic [CNT_W-1:0]       period_compare_reg,
    output logic [CNT_W-1:0]       change_point_b_reg,
    output logic [CNT_W-1:0]       general_c_reg,
    output logic [CNT_W-1:0]       general_d_reg,
    output logic                   count_run_bit,
    output logic                   c_buffer_select,
    output logic                   d_buffer_select,
    output logic [3:0]             match_irq,
    output logic                   overflow_irq,
    output logic                   irq0_request,
    output logic                   irq0_level,
    // Pins
    input  wire logic              ext_count_clock_pin,
    input  wire logic              fast_onchip_osc,
    input  wire logic              ext_irq0_pin,
    output logic                   chan_pin_a_out,
    output logic                   chan_pin_a_oe,
    output logic [NPWM-1:0]        chan_pin_bcd_out,
    output logic [NPWM-1:0]        chan_pin_bcd_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       s1;
        logic [2:0]       s2;
        logic [2:0]       s3;
        logic [2:0]       stable;
        logic [2:0]       prev;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] gb;
        logic [CNT_W-1:0] gc;
        logic [CNT_W-1:0] gd;
        logic             run;
        logic             bfc;
        logic             bfd;
        logic [NPWM-1:0]  lvl;
        logic [NPWM-1:0]  pin_out;
        logic [NPWM-1:0]  pin_oe;
        logic             a_out;
        logic             a_oe;
        logic [3:0]       match;
        logic             ovf;
        logic             irq0_ev;
    } mopwm_state_t;

    mopwm_state_t q;
    mopwm_state_t next_q;

    mopwm_src_if  src ();

    logic            tick;
    logic            period_hit;
    logic            cutoff;
    logic [NPWM-1:0] pwm_on;

    // Change point of PWM output i; B takes its point from the B register
    function automatic logic [CNT_W-1:0] mopwm_point(input mopwm_state_t s, input int i);
        logic [CNT_W-1:0] r;
        r = s.gb;
        if (i == 1)
            r = s.gc;
        else if (i == 2)
            r = s.gd;
        return r;
    endfunction : mopwm_point

    // ------------------------------------------------------------
    // Count source
    // ------------------------------------------------------------
    mopwm_prescale u_prescale (
        .clk (clk),
        .rst (rst),
        .src (src.div)
    );

    // Edges come from the settled copies, never from the first stage
    assign src.src_sel  = count_src_sel;
    assign src.ext_rise = q.stable[SY_EXT] & ~q.prev[SY_EXT];
    assign src.osc_rise = q.stable[SY_OSC] & ~q.prev[SY_OSC];

    // Counting happens only while the run bit is set
    assign tick       = src.tick & q.run;
    assign period_hit = q.cnt == q.period;
    assign cutoff     = (irq0_func == IRQ0_CUT) & ~q.stable[SY_IRQ0];

    // A buffer register gives up its own output pin
    assign pwm_on = pwm_enable & {~q.bfd, ~q.bfc, 1'b1};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_q         = q;
        next_q.match   = '0;
        next_q.ovf     = 1'b0;
        next_q.irq0_ev = 1'b0;

        // Three-stage sync; a level counts once stages two and three agree
        next_q.s1   = {ext_irq0_pin, fast_onchip_osc, ext_count_clock_pin};
        next_q.s2   = q.s1;
        next_q.s3   = q.s2;
        next_q.prev = q.stable;
        for (int k = 0; k < 3; k++)
        begin
            if (q.s2[k] == q.s3[k])
                next_q.stable[k] = q.s3[k];
        end
        if (irq0_func == IRQ0_INT && q.prev[SY_IRQ0] && !q.stable[SY_IRQ0])
            next_q.irq0_ev = 1'b1;

        if (tick)
        begin
            // Every general register match raises a request
            next_q.match = {q.cnt == q.gd, q.cnt == q.gc, q.cnt == q.gb, period_hit};
            if (period_hit)
            begin
                next_q.cnt = CNT_RST;
                // Buffered values land only at the period boundary
                if (q.bfc)
                    next_q.period = q.gc;
                if (q.bfd)
                    next_q.gb = q.gd;
            end
            else
            begin
                next_q.cnt = q.cnt + 16'h0001;
                next_q.ovf = q.cnt == CNT_MAX;
            end
        end

        // All outputs share the one period register
        for (int i = 0; i < NPWM; i++)
        begin
            if (pwm_on[i] && tick && mopwm_point(q, i) != q.period)
            begin
                if (q.cnt == mopwm_point(q, i))
                    next_q.lvl[i] = active_high[i];
                else if (period_hit)
                    next_q.lvl[i] = ~active_high[i];
            end
        end

        // Initial level is driven straight away on the control write
        if (output_ctrl_wr)
            next_q.lvl = init_level;

        // Software writes win over the count in the same cycle
        if (mode_ctrl_wr)
        begin
            next_q.run = mode_ctrl_data[MODE_RUN];
            next_q.bfc = mode_ctrl_data[MODE_BFC];
            next_q.bfd = mode_ctrl_data[MODE_BFD];
        end
        if (wr_counter)
            next_q.cnt = wr_data;
        if (wr_period)
            next_q.period = wr_data;
        if (wr_general_b)
            next_q.gb = wr_data;
        if (wr_general_c)
            next_q.gc = wr_data;
        if (wr_general_d)
            next_q.gd = wr_data;

        // Pin drive; cutoff releases PWM pins but leaves plain I/O alone
        for (int i = 0; i < NPWM; i++)
        begin
            next_q.pin_out[i] = pwm_on[i] ? next_q.lvl[i] : gpio_out[i+1];
            next_q.pin_oe[i]  = pwm_on[i] ? ~cutoff : gpio_oe[i+1];
        end
        next_q.a_out = gpio_out[0];
        next_q.a_oe  = gpio_oe[0];
    end

    // State register; general registers reset to the top code
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q        <= '0;
            q.period <= REG_RST;
            q.gb     <= REG_RST;
            q.gc     <= REG_RST;
            q.gd     <= REG_RST;
        end
        else
            q <= next_q;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pwm_counter        = q.cnt;
    assign period_compare_reg = q.period;
    assign change_point_b_reg = q.gb;
    assign general_c_reg      = q.gc;
    assign general_d_reg      = q.gd;
    assign count_run_bit      = q.run;
    assign c_buffer_select    = q.bfc;
    assign d_buffer_select    = q.bfd;
    assign match_irq          = q.match;
    assign overflow_irq       = q.ovf;
    assign irq0_request       = q.irq0_ev;
    assign irq0_level         = q.stable[SY_IRQ0];
    assign chan_pin_a_out     = q.a_out;
    assign chan_pin_a_oe      = q.a_oe;
    assign chan_pin_bcd_out   = q.pin_out;
    assign chan_pin_bcd_oe    = q.pin_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    period_wrap_a: assert property (@(posedge clk) disable iff (rst)
        tick && period_hit && !wr_counter |=> q.cnt == CNT_RST && !q.ovf && q.match[0])
        else $error("counter did not restart at period match");

    stop_hold_a: assert property (@(posedge clk) disable iff (rst)
        !q.run && !mode_ctrl_wr && !wr_counter && !output_ctrl_wr |=> $stable(q.cnt) && $stable(q.lvl))
        else $error("counter or level moved while stopped");

    equal_point_a: assert property (@(posedge clk) disable iff (rst)
        pwm_on[0] && q.gb == q.period && !output_ctrl_wr |=> q.lvl[0] == $past(q.lvl[0]))
        else $error("level changed with point equal to period");

    active_edge_a: assert property (@(posedge clk) disable iff (rst)
        pwm_on[0] && tick && q.cnt == q.gb && q.gb != q.period && !output_ctrl_wr
        |=> q.lvl[0] == $past(active_high[0]) ##1 chan_pin_bcd_out[0] == q.lvl[0])
        else $error("pin B not active after its change point");

    init_level_a: assert property (@(posedge clk) disable iff (rst)
        output_ctrl_wr && pwm_on[1] |=> chan_pin_bcd_out[1] == $past(init_level[1]))
        else $error("initial level not driven after control write");

    buffer_load_a: assert property (@(posedge clk) disable iff (rst)
        tick && period_hit && q.bfc && !wr_period |=> q.period == $past(q.gc))
        else $error("buffered period not loaded at period match");

    overflow_req_a: assert property (@(posedge clk) disable iff (rst)
        tick && q.cnt == CNT_MAX && !period_hit && !wr_counter |=> overflow_irq && q.cnt == CNT_RST)
        else $error("overflow request missing");

    counter_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_counter |=> pwm_counter == $past(wr_data))
        else $error("counter write not taken");

    c_buffer_pin_a: assert property (@(posedge clk) disable iff (rst)
        q.bfc && !gpio_oe[2] |=> !chan_pin_bcd_oe[1])
        else $error("pin C driven while it buffers the period");

    cutoff_pins_a: assert property (@(posedge clk) disable iff (rst)
        cutoff && pwm_on[0] |=> !chan_pin_bcd_oe[0])
        else $error("PWM pin still driven during cutoff");

    // Each general register raises its own request on a tick match
    match_b_a: assert property (@(posedge clk) disable iff (rst)
        tick && q.cnt == q.gb |=> q.match[1])
        else $error("B match request missing");

    match_c_a: assert property (@(posedge clk) disable iff (rst)
        tick && q.cnt == q.gc |=> q.match[2])
        else $error("C match request missing");

    match_d_a: assert property (@(posedge clk) disable iff (rst)
        tick && q.cnt == q.gd |=> q.match[3])
        else $error("D match request missing");

    no_tick_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !tick |=> q.match == 4'h0 && !q.ovf)
        else $error("request raised without a count tick");

    count_step_a: assert property (@(posedge clk) disable iff (rst)
        tick && !period_hit && !wr_counter |=> q.cnt == $past(q.cnt) + 16'h0001)
        else $error("counter did not step up by one");

    run_write_a: assert property (@(posedge clk) disable iff (rst)
        mode_ctrl_wr |=> q.run == $past(mode_ctrl_data[MODE_RUN]))
        else $error("run bit write not taken");

    period_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_period |=> period_compare_reg == $past(wr_data))
        else $error("period write not taken");

    point_b_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_general_b |=> change_point_b_reg == $past(wr_data))
        else $error("B point write not taken");

    // Buffer transfers happen at the period boundary and nowhere else
    d_buffer_load_a: assert property (@(posedge clk) disable iff (rst)
        tick && period_hit && q.bfd && !wr_general_b |=> q.gb == $past(q.gd))
        else $error("buffered B point not loaded at period match");

    no_early_load_a: assert property (@(posedge clk) disable iff (rst)
        !(tick && period_hit) && !wr_period |=> $stable(q.period))
        else $error("period changed away from the boundary");

    inactive_edge_a: assert property (@(posedge clk) disable iff (rst)
        pwm_on[0] && tick && period_hit && q.cnt != q.gb && !output_ctrl_wr |=> q.lvl[0] == ~$past(active_high[0]))
        else $error("pin B not inactive after period match");

    // Pin muxing between PWM and plain I/O
    pin_a_io_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> chan_pin_a_out == $past(gpio_out[0]) && chan_pin_a_oe == $past(gpio_oe[0]))
        else $error("pin A does not follow its I/O drive");

    io_pin_b_a: assert property (@(posedge clk) disable iff (rst)
        !pwm_on[0] |=> chan_pin_bcd_out[0] == $past(gpio_out[1]) && chan_pin_bcd_oe[0] == $past(gpio_oe[1]))
        else $error("pin B does not follow its I/O drive");

    pwm_drive_a: assert property (@(posedge clk) disable iff (rst)
        pwm_on[0] && !cutoff |=> chan_pin_bcd_oe[0])
        else $error("PWM pin B not driven");

    d_buffer_pin_a: assert property (@(posedge clk) disable iff (rst)
        q.bfd && !gpio_oe[3] |=> !chan_pin_bcd_oe[2])
        else $error("pin D driven while it buffers the B point");

    irq0_quiet_a: assert property (@(posedge clk) disable iff (rst)
        irq0_func != IRQ0_INT |=> !irq0_request)
        else $error("pin interrupt raised outside interrupt use");

endmodule : mopwm_top

// ==== tb/mopwm_load.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// External load on one PWM pin
// ------------------------------------------------------------
module mopwm_load (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   drive,
    input  wire logic   oe,
    input  wire logic   act_high,
    output logic [15:0] act_len,
    output logic [15:0] inact_len
);
    logic        active;
    logic        prev;
    logic [15:0] run;

    // A released pin is pulled low by the load, so it never shows a stale level
    assign active = ((oe ? drive : 1'b0) == act_high);

    // Lengths of the last finished active and inactive runs, in clock cycles
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev      <= 1'b0;
            run       <= 16'h0001;
            act_len   <= 16'h0000;
            inact_len <= 16'h0000;
        end
        else
        begin
            prev <= active;
            if (active != prev)
            begin
                if (prev)
                    act_len <= run;
                else
                    inact_len <= run;
                run <= 16'h0001;
            end
            else
                run <= run + 16'h0001;
        end
    end
endmodule : mopwm_load

// ==== tb/multi_output_pwm_mode_tb.sv ====
`timescale 1ns/1ps
module multi_output_pwm_mode_tb
    import mopwm_pkg::*;
;
    localparam logic [15:0] DIVS [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0020};
    logic        clk, rst, mode_wr, oc_wr, ext_pin, osc_pin, irq_pin;
    logic [2:0]  mode_d, src, pen, act_hi, init_lv, bcd_out, bcd_oe;
    logic [1:0]  irq_fn;
    logic [4:0]  wr_s;
    logic [15:0] wr_d, cnt, per, gb, gc, gd, old;
    logic [15:0] al [3];
    logic [15:0] il [3];
    logic [3:0]  g_out, g_oe, mirq;
    logic [5:0]  seen;
    logic        run_b, bfc, bfd, ovf, irq_req, irq_lv, a_out, a_oe;
    int          errors, check_count, n;

    mopwm_top uut (.clk(clk), .rst(rst), .mode_ctrl_wr(mode_wr), .mode_ctrl_data(mode_d), .count_src_sel(src),
        .pwm_enable(pen), .active_high(act_hi), .output_ctrl_wr(oc_wr), .init_level(init_lv), .irq0_func(irq_fn),
        .wr_counter(wr_s[0]), .wr_period(wr_s[1]), .wr_general_b(wr_s[2]), .wr_general_c(wr_s[3]),
        .wr_general_d(wr_s[4]), .wr_data(wr_d), .gpio_out(g_out), .gpio_oe(g_oe), .pwm_counter(cnt),
        .period_compare_reg(per), .change_point_b_reg(gb), .general_c_reg(gc), .general_d_reg(gd),
        .count_run_bit(run_b), .c_buffer_select(bfc), .d_buffer_select(bfd), .match_irq(mirq),
        .overflow_irq(ovf), .irq0_request(irq_req), .irq0_level(irq_lv), .ext_count_clock_pin(ext_pin),
        .fast_onchip_osc(osc_pin), .ext_irq0_pin(irq_pin), .chan_pin_a_out(a_out), .chan_pin_a_oe(a_oe),
        .chan_pin_bcd_out(bcd_out), .chan_pin_bcd_oe(bcd_oe));

    // One load per PWM pin B, C, D
    for (genvar i = 0; i < 3; i++)
    begin : g_load
        mopwm_load ld (.clk(clk), .rst(rst), .drive(bcd_out[i]), .oe(bcd_oe[i]), .act_high(act_hi[i]),
            .act_len(al[i]), .inact_len(il[i]));
    end

    always #2 clk = ~clk;
    // Requests are one-cycle pulses, so they are collected here rather than polled
    always @(posedge clk) seen <= seen | {irq_req, ovf, mirq};

    // ------------------------------------------------------------
    // Bus helpers
    // ------------------------------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Strobe is dropped and one idle cycle follows, so back-to-back calls never collide
    task automatic wreg(input int k, input logic [15:0] d);
        wr_s[k] = 1'b1;
        wr_d = d;
        step(1);
        wr_s = 5'h00;
        step(1);
    endtask : wreg

    task automatic mode(input logic [2:0] d);
        mode_wr = 1'b1;
        mode_d = d;
        step(1);
        mode_wr = 1'b0;
        step(1);
    endtask : mode

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        chk("period after reset", 16'hFFFF, per);
        wreg(0, 16'h1234);
        chk("counter readback", 16'h1234, cnt);
        wreg(1, 16'h0009);
        wreg(2, 16'h0003);
        wreg(3, 16'h0005);
        wreg(4, 16'h0009);
        wreg(0, 16'h0000);
        chk("period reg", 16'h0009, per);
        chk("point b", 16'h0003, gb);
        chk("point c", 16'h0005, gc);
        chk("point d", 16'h0009, gd);
    endtask : t_regs

    // B high active, C low active, D point equal to the period
    task automatic t_pwm;
        pen = 3'h7;
        act_hi = 3'h5;
        init_lv = 3'h2;
        oc_wr = 1'b1;
        step(1);
        oc_wr = 1'b0;
        chk("initial pin levels", 16'h0002, 16'(bcd_out));
        mode(3'h1);
        step(40);
        chk("b active width", 16'h0006, al[0]);
        chk("b inactive width", 16'h0004, il[0]);
        chk("c active width", 16'h0004, al[1]);
        chk("c inactive width", 16'h0006, il[1]);
        chk("d level", 16'h0000, 16'(bcd_out[2]));
    endtask : t_pwm

    task automatic t_stop_irq;
        logic [15:0] pins;
        mode(3'h0);
        old = cnt;
        pins = 16'(bcd_out);
        step(10);
        chk("held counter", old, cnt);
        chk("held pins", pins, 16'(bcd_out));
        wreg(0, 16'hFFFF);
        seen = 6'h00;
        mode(3'h1);
        step(16);
        chk("match and overflow requests", 16'h001F, 16'(seen[4:0]));
    endtask : t_stop_irq

    // Buffered period and point are written mid-period and must wait for the boundary
    task automatic t_buffer;
        // Buffers first hold the live values, so the first boundary after enabling changes nothing
        wreg(3, 16'h0009);
        wreg(4, 16'h0003);
        mode(3'h7);
        chk("mode bits", 16'h0007, {13'h0000, bfd, bfc, run_b});
        n = 0;
        while (cnt !== 16'h0001 && n < 20)
        begin
            step(1);
            n++;
        end
        wreg(3, 16'h0013);
        wreg(4, 16'h0007);
        chk("period before boundary", 16'h0009, per);
        step(10);
        chk("period from c buffer", 16'h0013, per);
        chk("point b from d buffer", 16'h0007, gb);
        step(45);
        chk("b active width buffered", 16'h000C, al[0]);
        chk("b inactive width buffered", 16'h0008, il[0]);
        mode(3'h0);
    endtask : t_buffer

    task automatic t_source;
        for (int k = 0; k < 5; k++)
        begin
            src = 3'(k);
            mode(3'h1);
            for (int p = 0; p < 2; p++)
            begin
                old = cnt;
                n = 0;
                while (cnt === old && n < 70)
                begin
                    step(1);
                    n++;
                end
            end
            chk("ticks between counts", DIVS[k], 16'(n));
            mode(3'h0);
        end
        for (int j = 0; j < 2; j++)
        begin
            src = (j == 0) ? SRC_OSC : SRC_EXT;
            wreg(0, 16'h0000);
            mode(3'h1);
            repeat (5)
            begin
                ext_pin = 1'b1;
                osc_pin = 1'b1;
                step(4);
                ext_pin = 1'b0;
                osc_pin = 1'b0;
                step(4);
            end
            step(6);
            chk("edge counted source", 16'h0005, cnt);
            mode(3'h0);
        end
    endtask : t_source

    task automatic t_pins;
        pen = 3'h0;
        g_out = 4'hB;
        g_oe = 4'hF;
        step(2);
        chk("pin a drive", 16'h0003, {14'h0000, a_oe, a_out});
        chk("pins bcd as io", 16'h0005, 16'(bcd_out));
        pen = 3'h7;
        irq_fn = IRQ0_CUT;
        irq_pin = 1'b0;
        step(6);
        chk("cutoff releases pins", 16'h0000, 16'(bcd_oe));
        irq_pin = 1'b1;
        irq_fn = IRQ0_INT;
        step(6);
        chk("settled irq pin", 16'h0001, 16'(irq_lv));
        seen = 6'h00;
        irq_pin = 1'b0;
        step(8);
        chk("pin interrupt", 16'h0001, 16'(seen[5]));
    endtask : t_pins

    initial
    begin
        {clk, mode_wr, oc_wr, ext_pin, osc_pin} = 5'h00;
        rst = 1'b1;
        irq_pin = 1'b1;
        {mode_d, pen, act_hi, init_lv} = 12'h000;
        src = SRC_F1;
        irq_fn = IRQ0_GPIO;
        {wr_s, wr_d, g_out, g_oe, seen} = 35'h0;
        errors = 0;
        check_count = 0;
        step(4);
        rst = 1'b0;
        step(1);
        t_regs();
        t_pwm();
        t_stop_irq();
        t_buffer();
        t_source();
        t_pins();
        stop_test();
    end

    // Whole run is a few hundred cycles; this limit cuts off a hang
    initial
    begin
        #80000;
        errors++;
        stop_test();
    end
endmodule : multi_output_pwm_mode_tb
